// ===== verilog/dma_pkg.sv
`default_nettype none
package dma_pkg;

  localparam int NUM_CH = 4;

  // ****************************************
  // Channel transfer mode field
  // ****************************************
  localparam logic [1:0] MODE_INHIBIT  = 2'h0;
  localparam logic [1:0] MODE_SINGLE   = 2'h1;
  localparam logic [1:0] MODE_RESERVED = 2'h2;
  localparam logic [1:0] MODE_REPEAT   = 2'h3;

  // ****************************************
  // Request source class
  // ****************************************
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_SOFTWARE = 2'h1;
  localparam logic [1:0] SRC_EXT_FALL = 2'h2;
  localparam logic [1:0] SRC_EXT_BOTH = 2'h3;

  // ****************************************
  // Access area codes and bus-cycle coefficients
  // ****************************************
  localparam logic [2:0] AREA_INT_NOWAIT = 3'h0;
  localparam logic [2:0] AREA_INT_WAIT   = 3'h1;
  localparam logic [2:0] AREA_SFR        = 3'h2;
  localparam logic [2:0] AREA_SEP_WAIT0  = 3'h3;
  localparam logic [2:0] AREA_SEP_WAIT1  = 3'h4;
  localparam logic [2:0] AREA_SEP_WAIT2  = 3'h5;
  localparam logic [2:0] AREA_SEP_WAIT3  = 3'h6;
  localparam logic [2:0] AREA_MUX        = 3'h7;

  localparam logic [2:0] COEF_1 = 3'h1;
  localparam logic [2:0] COEF_2 = 3'h2;
  localparam logic [2:0] COEF_3 = 3'h3;
  localparam logic [2:0] COEF_4 = 3'h4;

  // Bus cycles per side for one transfer unit
  localparam logic [1:0] ACC_ONE = 2'h1;
  localparam logic [1:0] ACC_TWO = 2'h2;

  localparam int CNT_W = 5;

  // External pin level after reset, treated as idle high
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_CPU  = 3'b100
  } xfer_state_t;

endpackage
`default_nettype wire

// ===== verilog/dma_req_latch.sv
`timescale 1ns/1ps
`default_nettype none
module dma_req_latch (
  input  wire logic       mclk,          // System clock
  input  wire logic       resetn,        // Async reset, active low
  input  wire logic       bclk_fall,     // Bus-clock falling edge strobe
  input  wire logic       ext_pin,       // External request pin, asynchronous
  input  wire logic [1:0] src_sel,       // Request source class
  input  wire logic       periph_req,    // Peripheral interrupt request set pulse
  input  wire logic       sw_req_wr,     // Software request bit written with one
  input  wire logic       pend_wr,       // Pending bit written with one
  input  wire logic       start_clr,     // Transfer of this channel begins
  input  wire logic       disabled,      // Channel inhibited or count zero
  output logic            pending        // Pending request bit
);

  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_last_ff;
  logic pend_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_ff   <= dma_pkg::PIN_IDLE;
      pin_s2_ff   <= dma_pkg::PIN_IDLE;
      pin_last_ff <= dma_pkg::PIN_IDLE;
    end else begin
      pin_s1_ff <= ext_pin;
      pin_s2_ff <= pin_s1_ff;
      if (bclk_fall) begin
        pin_last_ff <= pin_s2_ff;
      end
    end
  end

  // ****************************************
  // Set sources
  // ****************************************
  wire fall_seen = bclk_fall & pin_last_ff & ~pin_s2_ff;
  wire edge_seen = bclk_fall & (pin_last_ff ^ pin_s2_ff);
  wire set_int   = (src_sel == dma_pkg::SRC_INTERNAL) & periph_req;
  wire set_sw    = (src_sel == dma_pkg::SRC_SOFTWARE) & sw_req_wr;
  wire set_ext   = ((src_sel == dma_pkg::SRC_EXT_FALL) & fall_seen) |
                   ((src_sel == dma_pkg::SRC_EXT_BOTH) & edge_seen);
  wire set_any   = set_int | set_sw | set_ext | pend_wr;
  // Set wins, so an event in the clearing cycle survives
  wire nxt_pend  = set_any | (pend_ff & ~(start_clr | disabled));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  assign pending = pend_ff;

endmodule
`default_nettype wire

// ===== verilog/dma_cycle_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dma_cycle_ctrl #(
  parameter int NUM_CH = dma_pkg::NUM_CH
) (
  input  wire logic                    mclk,                 // 40 MHz system clock
  input  wire logic                    resetn,               // Async reset, active low
  input  wire logic                    bclk_fall,            // Bus-clock falling edge strobe
  input  wire logic [2*NUM_CH-1:0]     mode_wdata,           // Mode fields, two bits per channel
  input  wire logic [NUM_CH-1:0]       mode_wr,              // Write strobe per mode field
  input  wire logic [NUM_CH-1:0]       transfer_unit_select, // 0 byte, 1 word
  input  wire logic [NUM_CH-1:0]       count_zero,           // Transfer count register is zero
  input  wire logic [2*NUM_CH-1:0]     request_source_select_reg, // Source class per channel
  input  wire logic [NUM_CH-1:0]       periph_req,           // Peripheral request set pulses
  input  wire logic [NUM_CH-1:0]       sw_req_wr,            // Software request bit written one
  input  wire logic [NUM_CH-1:0]       pend_wr,              // Pending bit written one
  input  wire logic [NUM_CH-1:0]       external_request_pin, // External pins, asynchronous
  input  wire logic [NUM_CH-1:0]       src_odd,              // Source address odd
  input  wire logic [NUM_CH-1:0]       dst_odd,              // Destination address odd
  input  wire logic [NUM_CH-1:0]       src_bus16,            // Source bus is word wide
  input  wire logic [NUM_CH-1:0]       dst_bus16,            // Destination bus is word wide
  input  wire logic [3*NUM_CH-1:0]     src_area,             // Source area code per channel
  input  wire logic [3*NUM_CH-1:0]     dst_area,             // Destination area code per channel
  input  wire logic                    cpu_access_done,      // CPU finished one bus access
  output logic [2*NUM_CH-1:0]          channel_mode_reg_low, // Mode fields readback
  output logic [NUM_CH-1:0]            pending_request_bit,  // Pending bits readback
  output logic [NUM_CH-1:0]            sw_req_rd,            // Software request readback
  output logic                         bus_hold,             // DMA owns the bus
  output logic [1:0]                   active_ch,            // Channel being served
  output logic                         xfer_start,           // Unit start pulse
  output logic                         unit_done,            // Unit end pulse
  output logic [1:0]                   read_cycles,          // Reads of current unit
  output logic [1:0]                   write_cycles,         // Writes of current unit
  output logic [dma_pkg::CNT_W-1:0]    unit_cycles           // Bus cycles of current unit
);

  generate
    if (NUM_CH != 4) begin : g_bad_num_ch
      $error("dma_cycle_ctrl supports exactly four channels");
    end
  endgenerate

  // ****************************************
  // Channel mode fields
  // ****************************************
  logic [2*NUM_CH-1:0] mode_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= {NUM_CH{dma_pkg::MODE_INHIBIT}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (mode_wr[i]) begin
          mode_ff[2*i +: 2] <= mode_wdata[2*i +: 2];
        end
      end
    end
  end

  // ****************************************
  // Request latches and enables
  // ****************************************
  logic [NUM_CH-1:0] pend;
  logic [NUM_CH-1:0] enabled;
  logic [NUM_CH-1:0] disabled;
  logic [NUM_CH-1:0] start_clr;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire [1:0] ch_mode = mode_ff[2*g +: 2];
      // Reserved mode neither serves nor drops a request
      assign enabled[g]  = ((ch_mode == dma_pkg::MODE_SINGLE) |
                            (ch_mode == dma_pkg::MODE_REPEAT)) & ~count_zero[g];
      assign disabled[g] = (ch_mode == dma_pkg::MODE_INHIBIT) | count_zero[g];

      dma_req_latch u_latch (
        .mclk       (mclk),
        .resetn     (resetn),
        .bclk_fall  (bclk_fall),
        .ext_pin    (external_request_pin[g]),
        .src_sel    (request_source_select_reg[2*g +: 2]),
        .periph_req (periph_req[g]),
        .sw_req_wr  (sw_req_wr[g]),
        .pend_wr    (pend_wr[g]),
        .start_clr  (start_clr[g]),
        .disabled   (disabled[g]),
        .pending    (pend[g])
      );
    end
  endgenerate

  // ****************************************
  // Fixed priority selection
  // ****************************************
  function automatic logic [1:0] pick_lowest(input logic [NUM_CH-1:0] req);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = i[1:0];
      end
    end
    return idx;
  endfunction

  wire [NUM_CH-1:0] ready   = pend & enabled;
  wire              any_rdy = |ready;
  wire [1:0]        win_ch  = pick_lowest(ready);

  // ****************************************
  // Bus-cycle count of one unit
  // ****************************************
  function automatic logic [5:0] area_coef(input logic [2:0] area);
    logic [5:0] jk;
    case (area)
      dma_pkg::AREA_INT_NOWAIT: jk = {dma_pkg::COEF_1, dma_pkg::COEF_1};
      dma_pkg::AREA_INT_WAIT:   jk = {dma_pkg::COEF_2, dma_pkg::COEF_2};
      dma_pkg::AREA_SFR:        jk = {dma_pkg::COEF_2, dma_pkg::COEF_2};
      dma_pkg::AREA_SEP_WAIT0:  jk = {dma_pkg::COEF_1, dma_pkg::COEF_2};
      dma_pkg::AREA_SEP_WAIT1:  jk = {dma_pkg::COEF_2, dma_pkg::COEF_2};
      dma_pkg::AREA_SEP_WAIT2:  jk = {dma_pkg::COEF_3, dma_pkg::COEF_3};
      dma_pkg::AREA_SEP_WAIT3:  jk = {dma_pkg::COEF_4, dma_pkg::COEF_4};
      dma_pkg::AREA_MUX:        jk = {dma_pkg::COEF_3, dma_pkg::COEF_3};
      default:                  jk = {dma_pkg::COEF_1, dma_pkg::COEF_1};
    endcase
    return jk;
  endfunction

  wire       win_word  = transfer_unit_select[win_ch];
  // Parity only changes the count; no address mix is refused
  wire       rd_split  = win_word & (src_odd[win_ch] | ~src_bus16[win_ch]);
  wire       wr_split  = win_word & (dst_odd[win_ch] | ~dst_bus16[win_ch]);
  wire [1:0] nxt_rd    = rd_split ? dma_pkg::ACC_TWO : dma_pkg::ACC_ONE;
  wire [1:0] nxt_wr    = wr_split ? dma_pkg::ACC_TWO : dma_pkg::ACC_ONE;
  wire [5:0] src_jk    = area_coef(src_area[3*win_ch +: 3]);
  wire [5:0] dst_jk    = area_coef(dst_area[3*win_ch +: 3]);
  wire [2:0] coef_j    = src_jk[5:3];
  wire [2:0] coef_k    = dst_jk[2:0];
  // Operands widened first; a two by four product overflows three bits
  wire [dma_pkg::CNT_W-1:0] rd_part = dma_pkg::CNT_W'(nxt_rd) * dma_pkg::CNT_W'(coef_j);
  wire [dma_pkg::CNT_W-1:0] wr_part = dma_pkg::CNT_W'(nxt_wr) * dma_pkg::CNT_W'(coef_k);
  wire [dma_pkg::CNT_W-1:0] nxt_total = rd_part + wr_part;

  // ****************************************
  // Bus ownership sequence
  // ****************************************
  dma_pkg::xfer_state_t      state_ff;
  dma_pkg::xfer_state_t      nxt_state;
  logic [dma_pkg::CNT_W-1:0] left_ff;
  logic [1:0]                ch_ff;
  logic                      start_ff;
  logic                      done_ff;
  logic [1:0]                rd_ff;
  logic [1:0]                wr_ff;
  logic [dma_pkg::CNT_W-1:0] total_ff;

  wire grant    = (state_ff == dma_pkg::ST_IDLE) & any_rdy;
  wire last_cyc = (state_ff == dma_pkg::ST_XFER) & bclk_fall &
                  (left_ff == dma_pkg::CNT_W'(1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dma_pkg::ST_IDLE: begin
        if (any_rdy) begin
          nxt_state = dma_pkg::ST_XFER;
        end
      end
      dma_pkg::ST_XFER: begin
        if (last_cyc) begin
          nxt_state = dma_pkg::ST_CPU;
        end
      end
      dma_pkg::ST_CPU: begin
        if (cpu_access_done) begin
          nxt_state = dma_pkg::ST_IDLE;
        end
      end
      default: nxt_state = dma_pkg::ST_IDLE;
    endcase
  end

  assign start_clr = grant ? (NUM_CH'(1) << win_ch) : '0;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= dma_pkg::ST_IDLE;
      left_ff  <= '0;
      ch_ff    <= 2'h0;
      start_ff <= 1'b0;
      done_ff  <= 1'b0;
      rd_ff    <= 2'h0;
      wr_ff    <= 2'h0;
      total_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= grant;
      done_ff  <= last_cyc;
      if (grant) begin
        ch_ff    <= win_ch;
        left_ff  <= nxt_total;
        rd_ff    <= nxt_rd;
        wr_ff    <= nxt_wr;
        total_ff <= nxt_total;
      end else if ((state_ff == dma_pkg::ST_XFER) && bclk_fall) begin
        left_ff <= left_ff - dma_pkg::CNT_W'(1);
      end
    end
  end

  assign channel_mode_reg_low = mode_ff;
  assign pending_request_bit  = pend;
  assign sw_req_rd            = '0;
  assign bus_hold             = (state_ff == dma_pkg::ST_XFER);
  assign active_ch            = ch_ff;
  assign xfer_start           = start_ff;
  assign unit_done            = done_ff;
  assign read_cycles          = rd_ff;
  assign write_cycles         = wr_ff;
  assign unit_cycles          = total_ff;

endmodule
`default_nettype wire

// ===== test/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model #(
  parameter int BUS_DIV = 2
) (
  input  wire logic mclk,            // Clock
  input  wire logic resetn,          // Reset, active low
  input  wire logic unit_done,       // Transfer unit finished
  input  wire logic slow,            // Stretch the CPU access
  output var  logic bclk_fall,       // Bus-clock falling edge tick
  output var  logic cpu_access_done  // CPU bus access finished
);
  int div_cnt;
  int wait_cnt;
  // ****************************************
  // Bus ticks and one CPU access per unit
  // ****************************************
  // Slow accesses keep the arbiter waiting with requests still pending
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 0;
      wait_cnt <= 0;
      bclk_fall <= 1'b0;
      cpu_access_done <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == BUS_DIV - 1) ? 0 : div_cnt + 1;
      bclk_fall <= (div_cnt == BUS_DIV - 1);
      cpu_access_done <= (unit_done && !slow) || wait_cnt == 1;
      if (unit_done && slow)
        wait_cnt <= 4;
      else if (wait_cnt != 0)
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ===== test/dma_cycle_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dma_cycle_ctrl_checker #(
  parameter int NUM_CH = 4
) (
  input wire logic                mclk,                      // Clock
  input wire logic                resetn,                    // Reset
  input wire logic [2*NUM_CH-1:0] mode_wdata,                // Mode data
  input wire logic [NUM_CH-1:0]   mode_wr,                   // Mode strobe
  input wire logic [NUM_CH-1:0]   transfer_unit_select,      // Word unit
  input wire logic [NUM_CH-1:0]   count_zero,                // Count zero
  input wire logic [2*NUM_CH-1:0] request_source_select_reg, // Source
  input wire logic [NUM_CH-1:0]   periph_req,                // Peripheral
  input wire logic [NUM_CH-1:0]   sw_req_wr,                 // Software
  input wire logic [NUM_CH-1:0]   pend_wr,                   // Pending write
  input wire logic [NUM_CH-1:0]   src_odd,                   // Odd source
  input wire logic [NUM_CH-1:0]   src_bus16,                 // Word bus
  input wire logic [2*NUM_CH-1:0] channel_mode_reg_low,      // Modes
  input wire logic [NUM_CH-1:0]   pending_request_bit,       // Pending
  input wire logic [NUM_CH-1:0]   sw_req_rd,                 // Readback
  input wire logic                bus_hold,                  // Bus owned
  input wire logic [1:0]          active_ch,                 // Channel
  input wire logic                xfer_start,                // Start
  input wire logic                unit_done,                 // Done
  input wire logic [1:0]          read_cycles                // Reads
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  function automatic logic [NUM_CH-1:0] en_of(input logic [2*NUM_CH-1:0] m,
                                               input logic [NUM_CH-1:0] z);
    for (int i = 0; i < NUM_CH; i++)
      en_of[i] = m[2*i] & ~z[i];
  endfunction
  function automatic logic [1:0] rd_of(input logic [NUM_CH-1:0] u, o, b, input logic [1:0] c);
    return (u[c] && (o[c] || !b[c])) ? 2'h2 : 2'h1;
  endfunction
  // ****************************************
  // Properties
  // ****************************************
  property p_sw_zero; sw_req_rd == '0; endproperty
  a_sw_zero: assert property (p_sw_zero) else $error("software bit reads one");
  property p_periph; periph_req[0] && request_source_select_reg[1:0] == 2'h0
    |=> pending_request_bit[0]; endproperty
  a_periph: assert property (p_periph) else $error("peripheral request lost");
  property p_pend; |pend_wr |=> (pending_request_bit & $past(pend_wr)) == $past(pend_wr);
  endproperty
  a_pend: assert property (p_pend) else $error("pending write lost");
  property p_mode; mode_wr[0] |=> channel_mode_reg_low[1:0] == $past(mode_wdata[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode field not stored");
  property p_hold; xfer_start |-> bus_hold && !unit_done; endproperty
  a_hold: assert property (p_hold) else $error("start without bus");
  property p_reads; xfer_start |-> read_cycles ==
    rd_of($past(transfer_unit_select), $past(src_odd), $past(src_bus16), active_ch);
  endproperty
  a_reads: assert property (p_reads) else $error("read count wrong");
  property p_gap; unit_done |-> !bus_hold [*3]; endproperty
  a_gap: assert property (p_gap) else $error("bus not returned to cpu");
  property p_grant; xfer_start |-> |(en_of($past(channel_mode_reg_low), $past(count_zero))
    & $past(pending_request_bit) & (NUM_CH'(1) << active_ch)); endproperty
  a_grant: assert property (p_grant) else $error("grant to idle channel");
  property p_prio; xfer_start |-> (en_of($past(channel_mode_reg_low), $past(count_zero))
    & $past(pending_request_bit) & ((NUM_CH'(1) << active_ch) - NUM_CH'(1))) == '0;
  endproperty
  a_prio: assert property (p_prio) else $error("priority skipped");
  property p_clear; pending_request_bit[0] && channel_mode_reg_low[1:0] == 2'h0
    && !request_source_select_reg[1] && !(periph_req[0] || sw_req_wr[0] || pend_wr[0])
    |=> !pending_request_bit[0]; endproperty
  a_clear: assert property (p_clear) else $error("disabled pending kept");
endmodule
bind dma_cycle_ctrl dma_cycle_ctrl_checker #(.NUM_CH(NUM_CH)) u_checker (
  .mclk(mclk), .resetn(resetn), .mode_wdata(mode_wdata), .mode_wr(mode_wr),
  .transfer_unit_select(transfer_unit_select), .count_zero(count_zero),
  .request_source_select_reg(request_source_select_reg), .periph_req(periph_req),
  .sw_req_wr(sw_req_wr), .pend_wr(pend_wr), .src_odd(src_odd), .src_bus16(src_bus16),
  .channel_mode_reg_low(channel_mode_reg_low), .pending_request_bit(pending_request_bit),
  .sw_req_rd(sw_req_rd), .bus_hold(bus_hold), .active_ch(active_ch),
  .xfer_start(xfer_start), .unit_done(unit_done), .read_cycles(read_cycles));
`default_nettype wire

// ===== test/test_dma_cycle_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_dma_cycle_ctrl;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] mode_wdata = 8'h00, rsel = 8'h00, mode_rd;
  logic [3:0] mode_wr = 4'h0, tus = 4'h0, cz = 4'h0, periph = 4'h0, swr = 4'h0, pwr = 4'h0;
  logic [3:0] pins = 4'hF, s_odd = 4'h0, d_odd = 4'h0, s16 = 4'hF, d16 = 4'hF, pend, sw_rd;
  logic [11:0] s_area = 12'h000, d_area = 12'h000;
  logic slow = 1'b0;
  logic bclk_fall, cpu_access_done, bus_hold, xfer_start, unit_done;
  logic [1:0] act, rdc, wrc;
  logic [4:0] ucyc;
  logic [5:0] start_q[$];
  int fail_count = 0, samples_checked = 0, dones = 0, bcount = 0;
  always #12.5 mclk = ~mclk;
  dma_cycle_ctrl u_dut (
    .mclk(mclk), .resetn(resetn), .bclk_fall(bclk_fall), .mode_wdata(mode_wdata),
    .mode_wr(mode_wr), .transfer_unit_select(tus), .count_zero(cz),
    .request_source_select_reg(rsel), .periph_req(periph), .sw_req_wr(swr), .pend_wr(pwr),
    .external_request_pin(pins), .src_odd(s_odd), .dst_odd(d_odd), .src_bus16(s16),
    .dst_bus16(d16), .src_area(s_area), .dst_area(d_area), .cpu_access_done(cpu_access_done),
    .channel_mode_reg_low(mode_rd), .pending_request_bit(pend), .sw_req_rd(sw_rd),
    .bus_hold(bus_hold), .active_ch(act), .xfer_start(xfer_start), .unit_done(unit_done),
    .read_cycles(rdc), .write_cycles(wrc), .unit_cycles(ucyc));
  cpu_bus_model u_cpu (.mclk(mclk), .resetn(resetn), .unit_done(unit_done), .slow(slow),
    .bclk_fall(bclk_fall), .cpu_access_done(cpu_access_done));
  // ****************************************
  // Expectations and helpers
  // ****************************************
  function automatic int coef(input logic [2:0] a, input bit dst);
    case (a)
      3'h0: return 1;
      3'h1, 3'h2, 3'h4: return 2;
      3'h3: return dst ? 2 : 1;
      3'h6: return 4;
      default: return 3;
    endcase
  endfunction
  function automatic int sides(input logic u, o, b);
    return (u && (o || !b)) ? 2 : 1;
  endfunction
  function automatic int exp_cyc(input logic [1:0] c);
    return sides(tus[c], s_odd[c], s16[c]) * coef(s_area[3*c+:3], 1'b0)
         + sides(tus[c], d_odd[c], d16[c]) * coef(d_area[3*c+:3], 1'b1);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic pulse(ref logic [3:0] s, input logic [3:0] v);
    s = v;
    tick();
    s = 4'h0;
  endtask
  task automatic set_modes(input logic [7:0] m);
    mode_wdata = m;
    pulse(mode_wr, 4'hF);
    tick();
  endtask
  task automatic wait_units(input int n);
    int lim;
    lim = 0;
    n += dones;
    while (dones < n && lim < 3000) begin
      tick();
      lim++;
    end
    if (lim == 3000) check("unit completion", 0, 1);
    tick(8);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bus ticks counted while the bus is held must match the computed unit length
  always @(posedge mclk) begin
    if (xfer_start) begin
      bcount = bclk_fall ? 1 : 0;
      start_q.push_back({pend, act});
      check("start pending", pend[act], 1'b0);
      check("write cycles", wrc, sides(tus[act], d_odd[act], d16[act]));
      check("unit cycles", ucyc, exp_cyc(act));
    end else if (bus_hold && bclk_fall) bcount++;
    if (unit_done) begin
      dones++;
      check("bus ticks held", bcount, exp_cyc(act));
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    check("watchdog", 0, 1);
    final_report();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int i, ch;
    logic [7:0] m;
    void'($urandom(29));
    tick(2);
    resetn = 1'b1;
    tick(2);
    check("mode reset", mode_rd, 8'h00);
    check("pending reset", pend, 4'h0);
    rsel = 8'hE4;
    pulse(pwr, 4'hF);
    set_modes(8'hAA);
    check("reserved mode", mode_rd, 8'hAA);
    pulse(periph, 4'hF);
    check("peripheral set", pend, 4'h1);
    pulse(swr, 4'hF);
    check("software set", pend, 4'h3);
    check("software readback", sw_rd, 4'h0);
    pins = 4'hB;
    tick(10);
    check("falling pin two", pend, 4'h7);
    pins = 4'h3;
    tick(10);
    check("falling pin three", pend, 4'hF);
    set_modes(8'h00);
    check("inhibit clears", pend, 4'h0);
    set_modes(8'hAA);
    pins = 4'hF;
    tick(10);
    check("rising edges", pend, 4'h8);
    set_modes(8'h00);
    cz = 4'h2;
    set_modes(8'hFF);
    pulse(pwr, 4'h2);
    tick(4);
    check("count zero clears", pend, 4'h0);
    check("nothing served", start_q.size(), 0);
    cz = 4'h0;
    set_modes(8'h55);
    pulse(pwr, 4'hF);
    wait_units(4);
    for (i = 0; i < 4; i++)
      check("grant order", start_q[i], {4'hE << i, i[1:0]});
    for (i = 0; i < 32; i++) begin
      ch = int'($urandom % 4);
      m = 8'($urandom);
      m[2*ch+:2] = {m[2*ch+1], 1'b1};
      tus = 4'($urandom);
      s_odd = 4'($urandom);
      d_odd = 4'($urandom);
      s16 = 4'($urandom);
      d16 = 4'($urandom);
      s_area = (i < 8) ? {4{i[2:0]}} : 12'($urandom);
      d_area = (i < 8) ? {4{3'h7 - i[2:0]}} : 12'($urandom);
      slow = 1'($urandom);
      set_modes(m);
      start_q.delete();
      swr = 4'h1 << ch;
      pulse(pwr, 4'h1 << ch);
      swr = 4'h0;
      wait_units(1);
      check("served channel", start_q[0][1:0], ch[1:0]);
    end
    final_report();
  end
endmodule
`default_nettype wire
